/* File: common/bpl_pkg.sv */
// Shared constants and types for the block protection lock-down logic
package bpl_pkg;
   // Command opcodes taken from the serial link
   localparam logic [7:0] CMD_WRITE_ENABLE     = 8'h06;
   localparam logic [7:0] CMD_WRITE_DISABLE    = 8'h04;
   localparam logic [7:0] CMD_PROTECT_WRITE    = 8'h42;
   localparam logic [7:0] CMD_PROTECT_LOCKDOWN = 8'h8d;
   localparam logic [7:0] CMD_NV_LOCKDOWN      = 8'he8;
   localparam logic [7:0] CMD_GLOBAL_UNLOCK    = 8'h98;

   // Register and frame geometry
   localparam int          BP_WIDTH         = 80;
   localparam int          CNT_W            = 8;
   localparam logic [7:0]  CNT_ZERO         = 8'h00;
   localparam logic [7:0]  CNT_SAT          = 8'hff;
   localparam logic [7:0]  CMD_BITS         = 8'h08;
   localparam logic [7:0]  PAYLOAD_MIN_BITS = 8'h58;
   localparam logic [2:0]  BYTE_PHASE_ZERO  = 3'h0;
   localparam logic [7:0]  STEP_SPI         = 8'h01;
   localparam logic [7:0]  STEP_QUAD        = 8'h04;

   // Values after reset
   localparam logic [79:0] BP_RESET    = 80'h0;
   localparam logic [79:0] NV_RESET    = 80'h0;
   localparam logic [7:0]  CMD_RESET   = 8'h00;
   localparam logic        CS_IDLE     = 1'b1;

   // Write-lock bits: even bits 78..64 and every bit 63..0
   localparam logic [79:0] WRITE_LOCK_MASK = 80'h5555_ffff_ffff_ffff_ffff;
   // Read-lock bits: odd bits 79..65
   localparam logic [79:0] READ_LOCK_MASK  = 80'haaaa_0000_0000_0000_0000;

   // Page program time, longest figure, rounded down to whole cycles
   localparam real PAGE_PROGRAM_TIME_MS = 1.5;
   localparam real SYS_CLK_PERIOD_NS    = 10.0;
   localparam int  PAGE_PROGRAM_CYCLES  =
      int'($floor(PAGE_PROGRAM_TIME_MS * 1.0e6 / SYS_CLK_PERIOD_NS));
   localparam int          TIMER_W    = 18;
   localparam logic [17:0] TIMER_ZERO = 18'h0;
   localparam logic [17:0] TIMER_ONE  = 18'h1;

   // Control sequencer states
   typedef enum logic {
      BPL_IDLE,
      BPL_PROGRAM
   } bpl_state_t;
endpackage

/* File: design/bpl_link_rx.sv */
// Link-clock receiver that assembles command byte and payload of one frame
`timescale 1ns/1ps
module bpl_link_rx
   import bpl_pkg::*;
(
   input  wire logic                 link_sck,
   input  wire logic                 cs_n,
   input  wire logic                 quad_mode,
   input  wire logic [3:0]           sio_i,
   output logic      [7:0]           cmd_q,
   output logic      [BP_WIDTH-1:0]  payload_q,
   output logic      [CNT_W-1:0]     count_q
);
   logic             armed_q;   // Set while select is high, first edge restarts
   logic             quad_m_q;  // Mode synchroniser, first stage
   logic             quad_s_q;  // Mode synchroniser, second stage
   logic [CNT_W-1:0] base;      // Bit count before this edge
   logic [CNT_W-1:0] step;      // Bits taken on this edge

   // Frame start marker, raised by the select-high level before the frame
   always_ff @(posedge link_sck or posedge cs_n) begin
      if (cs_n) begin
         armed_q <= 1'b1;
      end else begin
         armed_q <= 1'b0;
      end
   end

   // Lane mode crosses into the link domain through two flops
   always_ff @(posedge link_sck) begin
      quad_m_q <= quad_mode;
      quad_s_q <= quad_m_q;
   end

   // Start count and lane step
   always_comb begin
      base = armed_q ? CNT_ZERO : count_q;
      step = quad_s_q ? STEP_QUAD : STEP_SPI;
   end

   // Saturating bit counter
   always_ff @(posedge link_sck) begin
      if (base > (CNT_SAT - step)) begin
         count_q <= CNT_SAT;
      end else begin
         count_q <= base + step;
      end
   end

   always_ff @(posedge link_sck) begin
      if (base < CMD_BITS) begin
         cmd_q <= quad_s_q ? {cmd_q[3:0], sio_i} : {cmd_q[6:0], sio_i[0]};
      end else if (quad_s_q) begin
         payload_q <= {payload_q[BP_WIDTH-5:0], sio_i};
      end else begin
         payload_q <= {payload_q[BP_WIDTH-2:0], sio_i[0]};
      end
   end
endmodule // bpl_link_rx

/* File: design/bpl_prog_timer.sv */
// Self-timed programming interval counter
`timescale 1ns/1ps
module bpl_prog_timer
   import bpl_pkg::*;
(
   input  wire logic               sys_clk,
   input  wire logic               nrst,
   input  wire logic               start,
   input  wire logic [TIMER_W-1:0] cycles,
   output logic                    busy_q,
   output logic                    done_q
);
   logic [TIMER_W-1:0] cnt_q;  // Cycles left in the interval

   // Busy for exactly the loaded number of cycles, then one done pulse
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_q  <= TIMER_ZERO;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start && !busy_q) begin
            cnt_q  <= (cycles == TIMER_ZERO) ? TIMER_ONE : cycles;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            cnt_q <= cnt_q - TIMER_ONE;
            if (cnt_q == TIMER_ONE) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end
endmodule // bpl_prog_timer

/* File: design/bpl_protect_ctrl.sv */
// Block protection register with volatile and permanent lock-down control
//
// Functional notes
// - Volatile lock-down freezes the protection register
// - Lock-down state clears on power cycle
// - Lock-down is opcode 8DH alone in frame
// - Permanent lock-down selects alterable write-lock bits
// - Permanent lock is E8H plus data payload
// - Payload arrives most significant bit first
// - Select rising starts self-timed programming
// - Busy flag clears when programming completes
// - Programmed write-lock bits stay set forever; here reset clears them
// - Global unlock clears unlocked write bits
// - Global unlock is opcode 98H alone
// - Eighty bits: lock pairs, 32K, 64K blocks
// - Opcode 06H sets write-enable latch
`timescale 1ns/1ps
module bpl_protect_ctrl
   import bpl_pkg::*;
#(
   parameter int PROG_CYCLES = PAGE_PROGRAM_CYCLES
)
(
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   input  wire logic                 link_sck,
   input  wire logic                 cs_n,
   input  wire logic                 quad_mode,
   input  wire logic [3:0]           sio_i,
   output logic      [3:0]           sio_o,
   output logic      [3:0]           sio_oe,
   output logic      [BP_WIDTH-1:0]  block_protection,
   output logic      [BP_WIDTH-1:0]  nv_lock,
   output logic                      write_enable_latch,
   output logic                      protect_lockdown,
   output logic                      busy,
   output logic                      cmd_refused
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   ////////////////////////////////////////////////////////////////////////////

   // Frame content held in the link domain
   logic [7:0]          rx_cmd;        // Command byte of the last frame
   logic [BP_WIDTH-1:0] rx_payload;    // Last eighty data bits of the frame
   logic [CNT_W-1:0]    rx_count;      // Bits seen in the frame, saturating

   // Select synchroniser and edge detector
   logic                cs_meta_q;     // First stage, read only by next stage
   logic                cs_sync_q;     // Second stage
   logic                cs_prev_q;     // Delayed copy for the rising edge
   logic                frame_end;     // Select just went high

   // Snapshot of a finished frame in the system domain
   logic                frame_q;       // One-cycle pulse, frame ready to decode
   logic [7:0]          cmd_q;         // Captured command byte
   logic [BP_WIDTH-1:0] data_q;        // Captured payload
   logic [CNT_W-1:0]    count_q;       // Captured bit count

   // Frame shape checks
   logic                opcode_only;   // Exactly one command byte
   logic                payload_ok;    // Whole bytes, at least eighty data bits

   // Command decode
   logic                is_write_enable_cmd;       // Write-enable frame
   logic                is_wrdi;       // Write-disable frame
   logic                is_lockdown;   // Volatile lock-down frame
   logic                is_unlock;     // Global unlock frame
   logic                is_nvlock;     // Permanent lock-down frame
   logic                is_bpwrite;    // Protection register write frame
   logic                is_protect;    // Any command that needs the latch

   // Accepted actions
   logic                do_write_enable_cmd;       // Set the write-enable latch
   logic                do_wrdi;       // Clear the write-enable latch
   logic                do_lockdown;   // Freeze the protection register
   logic                do_unlock;     // Clear unlocked write-lock bits
   logic                do_nvlock;     // Start permanent programming
   logic                do_bpwrite;    // Load the protection register
   logic                refuse;        // Protection command dropped

   // Stored state
   bpl_state_t          state_q;       // Control sequencer
   logic                wel_q;         // Write-enable latch
   logic                lock_q;        // Volatile lock-down
   logic [BP_WIDTH-1:0] bp_q;          // Block protection register
   logic [BP_WIDTH-1:0] nv_q;          // Permanent write-lock bits
   logic [BP_WIDTH-1:0] nv_pend_q;     // Bits waiting to be programmed
   logic                refused_q;     // Refusal pulse register

   // Programming timer
   logic                tmr_busy;      // Interval running
   logic                tmr_done;      // Interval finished, one cycle
   logic                prog_busy;     // Sequencer or timer still busy

   ////////////////////////////////////////////////////////////////////////////
   // Link domain
   ////////////////////////////////////////////////////////////////////////////

   bpl_link_rx u_link_rx (
      .link_sck  (link_sck),
      .cs_n      (cs_n),
      .quad_mode (quad_mode),
      .sio_i     (sio_i),
      .cmd_q     (rx_cmd),
      .payload_q (rx_payload),
      .count_q   (rx_count)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Frame crossing into the system domain
   ////////////////////////////////////////////////////////////////////////////

   // Two-flop select synchroniser plus edge history
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cs_meta_q <= CS_IDLE;
         cs_sync_q <= CS_IDLE;
         cs_prev_q <= CS_IDLE;
      end else begin
         cs_meta_q <= cs_n;
         cs_sync_q <= cs_meta_q;
         cs_prev_q <= cs_sync_q;
      end
   end

   // Rising select marks the end of a frame
   assign frame_end = cs_sync_q && !cs_prev_q;

   // Link registers are quiet once select is high, so sample them here
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         frame_q <= 1'b0;
         cmd_q   <= CMD_RESET;
         data_q  <= BP_RESET;
         count_q <= CNT_ZERO;
      end else begin
         frame_q <= frame_end;
         if (frame_end) begin
            cmd_q   <= rx_cmd;
            data_q  <= rx_payload;
            count_q <= rx_count;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode
   ////////////////////////////////////////////////////////////////////////////

   // Frame length checks
   always_comb begin
      opcode_only = (count_q == CMD_BITS);
      payload_ok  = (count_q >= PAYLOAD_MIN_BITS) && (count_q[2:0] == BYTE_PHASE_ZERO);
   end

   // Recognise the opcode of a captured frame
   always_comb begin
      is_write_enable_cmd     = frame_q && (cmd_q == CMD_WRITE_ENABLE) && opcode_only;
      is_wrdi     = frame_q && (cmd_q == CMD_WRITE_DISABLE) && opcode_only;
      is_lockdown = frame_q && (cmd_q == CMD_PROTECT_LOCKDOWN) && opcode_only;
      is_unlock   = frame_q && (cmd_q == CMD_GLOBAL_UNLOCK) && opcode_only;
      is_nvlock   = frame_q && (cmd_q == CMD_NV_LOCKDOWN) && payload_ok;
      is_bpwrite  = frame_q && (cmd_q == CMD_PROTECT_WRITE) && payload_ok;
      is_protect  = is_lockdown || is_unlock || is_nvlock || is_bpwrite;
   end

   // Busy covers the whole programming interval
   assign prog_busy = tmr_busy || (state_q == BPL_PROGRAM);

   // Decide which frame is acted on
   always_comb begin
      do_write_enable_cmd     = is_write_enable_cmd && !prog_busy;
      do_wrdi     = is_wrdi && !prog_busy;
      do_lockdown = is_lockdown && wel_q && !prog_busy;
      do_unlock   = is_unlock && wel_q && !prog_busy && !lock_q;
      do_bpwrite  = is_bpwrite && wel_q && !prog_busy && !lock_q;
      do_nvlock   = is_nvlock && wel_q && !prog_busy && !lock_q;
      refuse      = is_protect && !(do_lockdown || do_unlock || do_bpwrite || do_nvlock);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write-enable latch and volatile lock-down
   ////////////////////////////////////////////////////////////////////////////

   // Latch set by write enable, cleared by write disable or a used command
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         wel_q <= 1'b0;
      end else if (do_write_enable_cmd) begin
         wel_q <= 1'b1;
      end else if (do_wrdi || do_lockdown || do_unlock || do_bpwrite) begin
         // Lock-down, unlock and register load consume the latch at once
         wel_q <= 1'b0;
      end else if (tmr_done) begin
         // Permanent programming consumes it at completion
         wel_q <= 1'b0;
      end
   end

   // Lock-down stays until reset, which stands for a power cycle
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         lock_q <= 1'b0;
      end else if (do_lockdown) begin
         lock_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Permanent programming sequencer
   ////////////////////////////////////////////////////////////////////////////

   // Idle until a permanent lock-down, then wait out the timer
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_q <= BPL_IDLE;
      end else begin
         unique case (state_q)
            BPL_IDLE: begin
               if (do_nvlock) begin
                  state_q <= BPL_PROGRAM;
               end
            end
            BPL_PROGRAM: begin
               if (tmr_done) begin
                  state_q <= BPL_IDLE;
               end
            end
         endcase
      end
   end

   // Hold the write-lock bits chosen by the payload during programming
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         nv_pend_q <= NV_RESET;
      end else if (do_nvlock) begin
         nv_pend_q <= data_q & WRITE_LOCK_MASK;
      end
   end

   // Self-timed interval of one page program time
   bpl_prog_timer u_prog_timer (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .start   (do_nvlock),
      .cycles  (TIMER_W'(PROG_CYCLES)),
      .busy_q  (tmr_busy),
      .done_q  (tmr_done)
   );

   // Permanent bits only gain ones, and only reset clears them
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         nv_q <= NV_RESET;
      end else if (tmr_done) begin
         nv_q <= nv_q | nv_pend_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Block protection register
   ////////////////////////////////////////////////////////////////////////////

   // Loads, unlocks and programming all keep permanent bits set
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         bp_q <= BP_RESET;
      end else if (do_bpwrite) begin
         bp_q <= data_q | nv_q;
      end else if (do_unlock) begin
         bp_q <= (bp_q & READ_LOCK_MASK) | nv_q;
      end else if (tmr_done) begin
         bp_q <= bp_q | nv_pend_q;
      end
   end

   // Refusal is flagged for one cycle
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         refused_q <= 1'b0;
      end else begin
         refused_q <= refuse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   ////////////////////////////////////////////////////////////////////////////

   assign block_protection   = bp_q;
   assign nv_lock            = nv_q;
   assign write_enable_latch = wel_q;
   assign protect_lockdown   = lock_q;
   assign busy               = prog_busy;
   assign cmd_refused        = refused_q;

   // No read command lives here, so the lanes are never driven
   assign sio_o  = 4'h0;
   assign sio_oe = 4'h0;

endmodule // bpl_protect_ctrl

/* File: dv/bpl_host.sv */
// Host-side model that frames commands onto the serial lanes
`timescale 1ns/1ps
module bpl_host
   import bpl_pkg::*;
(
   output logic       link_sck,
   output logic       cs_n,
   output logic       quad_mode,
   output logic [3:0] sio_i
);
   // Idle bus: clock still, select high
   initial begin
      link_sck  = 1'b0;
      cs_n      = 1'b0;
      quad_mode = 1'b0;
      sio_i     = 4'h5;
      // A select rise at start sets the frame marker before the first frame
      #1 cs_n = CS_IDLE;
   end

   // Sends opcode then nbytes of payload on an 80 ns link clock
   task automatic send(input logic [7:0] op, input logic [79:0] d, input int nbytes,
                       input logic quad);
      logic [87:0] sh;
      int          nclk;
      sh = {op, d};
      nclk = quad ? (8 + 8 * nbytes) / 4 : 8 + 8 * nbytes;
      // Offset keeps link edges off the system clock phase
      #13;
      // Lane mode needs a few link edges to settle
      if (quad_mode !== quad) begin
         quad_mode = quad;
         repeat (3) begin
            #40 link_sck = 1'b1;
            #40 link_sck = 1'b0;
         end
      end
      cs_n = 1'b0;
      #80;
      for (int i = 0; i < nclk; i++) begin
         sio_i = quad ? sh[87:84] : {~sio_i[3:1], sh[87]};
         sh = quad ? sh << 4 : sh << 1;
         #40 link_sck = 1'b1;
         #40 link_sck = 1'b0;
      end
      #40 cs_n = CS_IDLE;
      // Released lanes show the inverse of the last value
      sio_i = ~sio_i;
      #100;
   endtask
endmodule // bpl_host

/* File: dv/bpl_protect_ctrl_properties.sv */
// Concurrent checks on the protection controller ports
`timescale 1ns/1ps
module bpl_protect_ctrl_properties
   import bpl_pkg::*;
#(
   parameter int PROG_CYCLES = 20
)
(
   input wire logic                sys_clk,
   input wire logic                nrst,
   input wire logic                link_sck,
   input wire logic                cs_n,
   input wire logic                quad_mode,
   input wire logic [3:0]          sio_i,
   input wire logic [3:0]          sio_o,
   input wire logic [3:0]          sio_oe,
   input wire logic [BP_WIDTH-1:0] block_protection,
   input wire logic [BP_WIDTH-1:0] nv_lock,
   input wire logic                write_enable_latch,
   input wire logic                protect_lockdown,
   input wire logic                busy,
   input wire logic                cmd_refused
);
   // Longest busy interval tolerated
   localparam int BUSY_MAX = PROG_CYCLES + 4;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   a_lock_holds: assert property (protect_lockdown |=> protect_lockdown)
      else $error("lock-down dropped");
   a_bp_frozen: assert property (protect_lockdown |=> $stable(block_protection))
      else $error("protection changed under lock-down");
   a_lock_needs_wel: assert property ($rose(protect_lockdown) |->
      $past(write_enable_latch) && !write_enable_latch) else $error("lock-down without enable");
   a_bp_needs_wel: assert property ($changed(block_protection) |->
      $past(write_enable_latch)) else $error("protection changed without enable");
   a_nv_sticky: assert property ((nv_lock & $past(nv_lock)) == $past(nv_lock))
      else $error("permanent lock bit cleared");
   a_nv_in_bp: assert property ((block_protection & nv_lock) == nv_lock)
      else $error("permanent bit missing from protection");
   // permanent bits only on write locks
   a_nv_mask: assert property ((nv_lock & ~WRITE_LOCK_MASK) == 80'h0)
      else $error("permanent bit on read lock");
   // permanent bits change only by programming
   a_nv_after_busy: assert property ($changed(nv_lock) |-> $past(busy))
      else $error("permanent bits changed while idle");
   a_busy_min: assert property ($rose(busy) |=> busy[*8])
      else $error("busy too short");
   a_busy_ends: assert property ($rose(busy) |-> ##[1:BUSY_MAX] !busy)
      else $error("busy never cleared");
   a_busy_no_lock: assert property (busy && $past(busy) |-> $stable(protect_lockdown))
      else $error("lock-down changed while busy");
endmodule // bpl_protect_ctrl_properties

bind bpl_protect_ctrl bpl_protect_ctrl_properties #(.PROG_CYCLES(PROG_CYCLES)) u_props (
   .sys_clk(sys_clk), .nrst(nrst), .link_sck(link_sck), .cs_n(cs_n),
   .quad_mode(quad_mode), .sio_i(sio_i), .sio_o(sio_o), .sio_oe(sio_oe),
   .block_protection(block_protection), .nv_lock(nv_lock),
   .write_enable_latch(write_enable_latch), .protect_lockdown(protect_lockdown),
   .busy(busy), .cmd_refused(cmd_refused));

/* File: dv/bpl_protect_ctrl_test.sv */
// Self-checking bench for the protection controller
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin bad_count++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module bpl_protect_ctrl_test
   import bpl_pkg::*;
;
   localparam int PROG  = 300;    // Shortened programming time
   localparam int LIMIT = 20000;  // Cycle ceiling for the run

   // Expected port state at one check point
   typedef struct packed {
      logic [79:0] bp;
      logic [79:0] nv;
      logic        wel;
      logic        lock;
      logic        busy;
      logic [7:0]  rc;
   } bpl_snap_t;

   logic               sys_clk = 1'b0;
   logic               nrst;
   logic               link_sck, cs_n, quad_mode;
   logic [3:0]         sio_i, sio_o, sio_oe;
   logic [79:0]        block_protection, nv_lock;
   logic               write_enable_latch, protect_lockdown, busy, cmd_refused;
   logic [79:0]        m_bp, m_nv, d;    // Reference model state
   logic               m_wel, m_lock, m_busy;
   logic [7:0]         m_ref;
   logic [7:0]         ref_seen = 8'h00; // Refusal pulses observed
   logic               chk_stb;
   bpl_snap_t          exp_q[$];
   bpl_snap_t          s;
   int                 seed, bad_count, n_tests, cycles;

   always #5 sys_clk = ~sys_clk;

   bpl_host u_bpl_host (.link_sck(link_sck), .cs_n(cs_n), .quad_mode(quad_mode),
                        .sio_i(sio_i));
   bpl_protect_ctrl #(.PROG_CYCLES(PROG)) u_bpl_protect_ctrl (
      .sys_clk(sys_clk), .nrst(nrst), .link_sck(link_sck), .cs_n(cs_n),
      .quad_mode(quad_mode), .sio_i(sio_i), .sio_o(sio_o), .sio_oe(sio_oe),
      .block_protection(block_protection), .nv_lock(nv_lock),
      .write_enable_latch(write_enable_latch), .protect_lockdown(protect_lockdown),
      .busy(busy), .cmd_refused(cmd_refused));

   ////////////////////////////////////////////////////////////////////////////////
   // Closing report
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         final_report();
      end
   end

   // Counts one-cycle refusal pulses
   always @(posedge sys_clk) begin
      if (cmd_refused === 1'b1) ref_seen <= ref_seen + 8'h01;
   end

   // Watcher compares the oldest note against the ports
   always @(posedge sys_clk) begin
      if (chk_stb === 1'b1 && exp_q.size() > 0) begin
         s = exp_q.pop_front();
         `CHK("block_protection", s.bp, block_protection)
         `CHK("nv_lock", s.nv, nv_lock)
         `CHK("write_enable_latch", s.wel, write_enable_latch)
         `CHK("protect_lockdown", s.lock, protect_lockdown)
         `CHK("busy", s.busy, busy)
         `CHK("refusals", s.rc, ref_seen)
         `CHK("lanes", 8'h00, {sio_oe, sio_o})
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Notes the model state and asks the watcher to compare
   task automatic expect_now;
      exp_q.push_back('{m_bp, m_nv, m_wel, m_lock, m_busy, m_ref});
      @(posedge sys_clk) #1 chk_stb = 1'b1;
      @(posedge sys_clk) #1 chk_stb = 1'b0;
   endtask

   // One frame followed by a check
   task automatic run(input logic [7:0] op, input logic [79:0] pd, input int nb,
                      input logic q);
      u_bpl_host.send(op, pd, nb, q);
      expect_now();
   endtask

   // Write enable frame
   task automatic write_enable_cmd(input logic q);
      m_wel = 1'b1;
      run(CMD_WRITE_ENABLE, 80'h0, 0, q);
   endtask

   // Fresh 80-bit random payload
   task automatic rnd_data;
      logic [95:0] r;
      r = {$random(seed), $random(seed), $random(seed)};
      d = r[79:0];
   endtask

   // Reset pulse held 12 cycles, model follows
   task automatic do_reset;
      @(posedge sys_clk) #1 nrst = 1'b0;
      repeat (12) @(posedge sys_clk);
      #1 nrst = 1'b1;
      {m_bp, m_nv, m_wel, m_lock, m_busy} = '0;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      seed = 95;
      nrst = 1'b0;
      chk_stb = 1'b0;
      m_ref = 8'h00;
      do_reset();
      expect_now();
      // load and permanent lock refused without enable
      rnd_data();
      m_ref++;
      run(CMD_PROTECT_WRITE, d, 10, 1'b0);
      m_ref++;
      run(CMD_NV_LOCKDOWN, d, 10, 1'b0);
      write_enable_cmd(1'b0);
      m_wel = 1'b0;
      run(CMD_WRITE_DISABLE, 80'h0, 0, 1'b1);
      write_enable_cmd(1'b1);
      m_bp = d;
      m_wel = 1'b0;
      run(CMD_PROTECT_WRITE, d, 10, 1'b1);
      write_enable_cmd(1'b0);
      rnd_data();
      m_busy = 1'b1;
      run(CMD_NV_LOCKDOWN, d, 10, 1'b0);
      // lock-down refused and disable ignored while busy
      m_ref++;
      run(CMD_PROTECT_LOCKDOWN, 80'h0, 0, 1'b0);
      run(CMD_WRITE_DISABLE, 80'h0, 0, 1'b0);
      for (int i = 0; i < 400 && busy !== 1'b0; i++) @(posedge sys_clk);
      m_busy = 1'b0;
      m_nv = d & WRITE_LOCK_MASK;
      m_bp = m_bp | m_nv;
      m_wel = 1'b0;
      repeat (3) @(posedge sys_clk);
      expect_now();
      write_enable_cmd(1'b1);
      // unlock with stray byte is ignored
      run(CMD_GLOBAL_UNLOCK, 80'h0, 1, 1'b1);
      // unlock keeps read and permanent bits
      m_bp = (m_bp & READ_LOCK_MASK) | m_nv;
      m_wel = 1'b0;
      run(CMD_GLOBAL_UNLOCK, 80'h0, 0, 1'b1);
      write_enable_cmd(1'b0);
      m_lock = 1'b1;
      m_wel = 1'b0;
      run(CMD_PROTECT_LOCKDOWN, 80'h0, 0, 1'b0);
      write_enable_cmd(1'b0);
      rnd_data();
      m_ref++;
      run(CMD_PROTECT_WRITE, d, 10, 1'b0);
      m_ref++;
      run(CMD_GLOBAL_UNLOCK, 80'h0, 0, 1'b0);
      m_ref++;
      run(CMD_NV_LOCKDOWN, d, 10, 1'b0);
      do_reset();
      expect_now();
      write_enable_cmd(1'b1);
      m_bp = d;
      m_wel = 1'b0;
      run(CMD_PROTECT_WRITE, d, 10, 1'b1);
      repeat (3) @(posedge sys_clk);
      final_report();
   end
endmodule // bpl_protect_ctrl_test
